/* hw/dcaxq_pkg.sv */
// Shared constants, register map and types for the DC axis encoder and drive-enable block
package dcaxq_pkg;

  // Clock and timing
  localparam int CLK_HZ         = 100_000_000;
  localparam int PWM_FREQ_HZ    = 32_000;
  // Fixed base period; integer division rounds down, so the rate is never below 32 kHz
  localparam int PWM_PERIOD_CYC = CLK_HZ / PWM_FREQ_HZ;
  localparam int VEL_WIN_US     = 1000;
  localparam int VEL_WIN_CYC    = (CLK_HZ / 1_000_000) * VEL_WIN_US;

  // Widths
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int POS_W  = 32;
  localparam int CUR_W  = 16;
  localparam int DUTY_W = 12;
  localparam int WIN_W  = 32;

  // Register byte offsets
  localparam logic [7:0] OFS_CTRL     = 8'h00;
  localparam logic [7:0] OFS_STATUS   = 8'h04;
  localparam logic [7:0] OFS_POSITION = 8'h08;
  localparam logic [7:0] OFS_VELOCITY = 8'h0c;
  localparam logic [7:0] OFS_CUR_SET  = 8'h10;
  localparam logic [7:0] OFS_LIM_POS  = 8'h14;
  localparam logic [7:0] OFS_LIM_NEG  = 8'h18;
  localparam logic [7:0] OFS_MAX_CUR  = 8'h1c;
  localparam logic [7:0] OFS_CFG      = 8'h20;

  // Field positions
  localparam int CFG_FOUR_EDGE_BIT = 0;
  localparam int ST_DIR_BIT        = 4;
  localparam int ST_RDY_BIT        = 8;
  localparam int ST_SWON_BIT       = 9;
  localparam int ST_OPEN_BIT       = 10;
  localparam int CW_VOLTAGE_BIT    = 1;

  // Control-word command codes in bits 3..0
  localparam logic [3:0] CW_SHUTDOWN_MASK = 4'h7;
  localparam logic [3:0] CW_SHUTDOWN      = 4'h6;
  localparam logic [3:0] CW_SWITCH_ON     = 4'h7;
  localparam logic [3:0] CW_ENABLE_OP     = 4'hf;

  // Values after reset
  localparam logic [3:0]  RST_CTRL      = 4'h0;
  localparam logic        RST_FOUR_EDGE = 1'b1;
  localparam logic [15:0] RST_CUR_SET   = 16'h0000;
  localparam logic [15:0] RST_CUR_LIMIT = 16'h0c35;

  typedef enum logic [1:0] {
    ST_SW_ON_DIS   = 2'b00,
    ST_READY       = 2'b01,
    ST_SWITCHED_ON = 2'b10,
    ST_OP_EN       = 2'b11
  } dcaxq_state_e;

  typedef struct packed {
    logic step;
    logic up;
  } dcaxq_step_s;

  typedef struct packed {
    logic [CUR_W-1:0] pos;
    logic [CUR_W-1:0] neg;
    logic [CUR_W-1:0] max;
  } dcaxq_lim_s;

endpackage

/* hw/dcaxq_quad.sv */
// Quadrature track synchroniser and single/four-edge step decoder
`timescale 1ns/1ns
module dcaxq_quad (
  // Clock and reset
  input  wire logic               clk,
  input  wire logic               rst,
  // Encoder tracks and mode
  input  wire logic               trk_a,
  input  wire logic               trk_b,
  input  wire logic               four_edge,
  // Decoded step
  output dcaxq_pkg::dcaxq_step_s  step
);

  logic [1:0]             sync1_ff;
  logic [1:0]             sync2_ff;
  logic [1:0]             prev_ff;
  logic [2:0]             primed_ff;
  dcaxq_pkg::dcaxq_step_s step_ff;
  logic [1:0]             nxt_prev;
  logic [2:0]             nxt_primed;
  dcaxq_pkg::dcaxq_step_s nxt_step;
  logic                   a_chg;
  logic                   b_chg;

  always_comb begin
    nxt_prev   = sync2_ff;
    nxt_primed = {primed_ff[1:0], 1'b1};
    nxt_step   = '0;
    a_chg      = sync2_ff[1] ^ prev_ff[1];
    b_chg      = sync2_ff[0] ^ prev_ff[0];
    // Compare only once synchroniser and history hold real samples,
    // so a track idling high after reset gives no false step
    if (primed_ff[2] && !(a_chg && b_chg)) begin
      if (four_edge) begin
        if (a_chg) begin
          nxt_step.step = 1'b1;
          nxt_step.up   = sync2_ff[1] ^ sync2_ff[0];
        end else if (b_chg) begin
          nxt_step.step = 1'b1;
          nxt_step.up   = ~(sync2_ff[1] ^ sync2_ff[0]);
        end
      end else if (a_chg && sync2_ff[1]) begin
        nxt_step.step = 1'b1;
        nxt_step.up   = ~sync2_ff[0];
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sync1_ff  <= 2'h0;
      sync2_ff  <= 2'h0;
      prev_ff   <= 2'h0;
      primed_ff <= 3'h0;
      step_ff   <= '0;
    end else begin
      sync1_ff  <= {trk_a, trk_b};
      sync2_ff  <= sync1_ff;
      prev_ff   <= nxt_prev;
      primed_ff <= nxt_primed;
      step_ff   <= nxt_step;
    end
  end

  assign step = step_ff;

endmodule

/* hw/dcaxq_pwm.sv */
// Fixed-period PWM generator with registered output
`timescale 1ns/1ns
module dcaxq_pwm #(
  parameter int PERIOD = dcaxq_pkg::PWM_PERIOD_CYC
) (
  // Clock and reset
  input  wire logic                          clk,
  input  wire logic                          rst,
  // Duty in clock cycles per period
  input  wire logic [dcaxq_pkg::DUTY_W-1:0]  duty,
  // Modulated level
  output logic                               pwm_on
);

  localparam logic [dcaxq_pkg::DUTY_W-1:0] LAST = dcaxq_pkg::DUTY_W'(PERIOD - 1);

  logic [dcaxq_pkg::DUTY_W-1:0] cnt_ff;
  logic                         on_ff;
  logic [dcaxq_pkg::DUTY_W-1:0] nxt_cnt;
  logic                         nxt_on;

  always_comb begin
    nxt_cnt = (cnt_ff == LAST) ? '0 : cnt_ff + 1'b1;
    nxt_on  = (cnt_ff < duty);
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_ff <= '0;
      on_ff  <= 1'b0;
    end else begin
      cnt_ff <= nxt_cnt;
      on_ff  <= nxt_on;
    end
  end

  assign pwm_on = on_ff;

endmodule

/* hw/dcaxq_top.sv */
// DC axis: encoder position and velocity, drive-enable sequence, limited PWM drive
//
// Overview of operation
// - A leading B means rotation right
// - A lagging B means rotation left
// - Single-edge: count only A rising edges
// - Four-edge: count every edge of A, B; here A and B changing in the same sample give no count
// - Pulse count is the travelled position
// - Velocity is difference of successive positions
// - Shutdown code x110 gives ready-to-switch-on
// - Switch-on code 0111 gives switched-on
// - Enable code 1111 gives operation enabled
// - Current clamped by direction and maximum limits
// - PWM at fixed 32 kHz base period
// - State changes only on host commands
//
// Chosen here: strobed register access and the register addresses.
`timescale 1ns/1ns
module dcaxq_top #(
  parameter int VEL_WIN_CYC = dcaxq_pkg::VEL_WIN_CYC
) (
  // Clock and reset
  input  wire logic                          CLK,
  input  wire logic                          RESET,
  // Register port
  input  wire logic [dcaxq_pkg::ADDR_W-1:0]  ADDR,
  input  wire logic [dcaxq_pkg::DATA_W-1:0]  WDATA,
  input  wire logic                          WR,
  input  wire logic                          RD,
  output logic      [dcaxq_pkg::DATA_W-1:0]  RDATA,
  // Encoder tracks
  input  wire logic                          TRACK_A,
  input  wire logic                          TRACK_B,
  // Power stage
  output logic                               MOTOR_P,
  output logic                               MOTOR_N,
  output logic                               DRIVE_EN
);

  localparam logic [dcaxq_pkg::WIN_W-1:0] WIN_LAST =
    dcaxq_pkg::WIN_W'(VEL_WIN_CYC - 1);
  localparam logic [dcaxq_pkg::CUR_W-1:0] PERIOD_CUR =
    dcaxq_pkg::CUR_W'(dcaxq_pkg::PWM_PERIOD_CYC);

  // Registered state
  dcaxq_pkg::dcaxq_state_e           state_ff;
  logic [3:0]                        ctrl_ff;
  logic                              four_edge_ff;
  logic [dcaxq_pkg::CUR_W-1:0]       cur_set_ff;
  dcaxq_pkg::dcaxq_lim_s             lim_ff;
  logic [dcaxq_pkg::POS_W-1:0]       pos_ff;
  logic [dcaxq_pkg::POS_W-1:0]       pos_prev_ff;
  logic [dcaxq_pkg::POS_W-1:0]       vel_ff;
  logic [dcaxq_pkg::WIN_W-1:0]       win_ff;
  logic                              dir_ff;
  logic [dcaxq_pkg::DATA_W-1:0]      rdata_ff;
  logic                              motor_p_ff;
  logic                              motor_n_ff;
  logic                              drive_en_ff;

  // Next values
  dcaxq_pkg::dcaxq_state_e           nxt_state;
  logic [3:0]                        nxt_ctrl;
  logic                              nxt_four_edge;
  logic [dcaxq_pkg::CUR_W-1:0]       nxt_cur_set;
  dcaxq_pkg::dcaxq_lim_s             nxt_lim;
  logic [dcaxq_pkg::POS_W-1:0]       nxt_pos;
  logic [dcaxq_pkg::POS_W-1:0]       nxt_pos_prev;
  logic [dcaxq_pkg::POS_W-1:0]       nxt_vel;
  logic [dcaxq_pkg::WIN_W-1:0]       nxt_win;
  logic                              nxt_dir;
  logic [dcaxq_pkg::DATA_W-1:0]      nxt_rdata;
  logic                              nxt_motor_p;
  logic                              nxt_motor_n;
  logic                              nxt_drive_en;

  // Internal
  dcaxq_pkg::dcaxq_step_s            step;
  logic                              pwm_on;
  logic [dcaxq_pkg::DUTY_W-1:0]      duty;
  logic                              cur_neg;
  logic [dcaxq_pkg::CUR_W-1:0]       cur_mag;
  logic [dcaxq_pkg::CUR_W-1:0]       cur_lim;
  logic [dcaxq_pkg::CUR_W-1:0]       cur_eff;
  logic [3:0]                        cw;
  logic                              cw_wr;

  dcaxq_quad u_quad (
    .clk       (CLK),
    .rst       (RESET),
    .trk_a     (TRACK_A),
    .trk_b     (TRACK_B),
    .four_edge (four_edge_ff),
    .step      (step)
  );

  dcaxq_pwm #(
    .PERIOD (dcaxq_pkg::PWM_PERIOD_CYC)
  ) u_pwm (
    .clk    (CLK),
    .rst    (RESET),
    .duty   (duty),
    .pwm_on (pwm_on)
  );

  // Drive state machine: moves only on a control-word write
  always_comb begin
    cw        = WDATA[3:0];
    cw_wr     = WR && (ADDR == dcaxq_pkg::OFS_CTRL);
    nxt_state = state_ff;
    nxt_ctrl  = ctrl_ff;
    if (cw_wr) begin
      nxt_ctrl = cw;
      if (!cw[dcaxq_pkg::CW_VOLTAGE_BIT]) begin
        // Disable voltage drops the drive from any state
        nxt_state = dcaxq_pkg::ST_SW_ON_DIS;
      end else begin
        case (state_ff)
          dcaxq_pkg::ST_SW_ON_DIS: begin
            if ((cw & dcaxq_pkg::CW_SHUTDOWN_MASK) == dcaxq_pkg::CW_SHUTDOWN) begin
              nxt_state = dcaxq_pkg::ST_READY;
            end
          end
          dcaxq_pkg::ST_READY: begin
            if (cw == dcaxq_pkg::CW_SWITCH_ON) begin
              nxt_state = dcaxq_pkg::ST_SWITCHED_ON;
            end
          end
          dcaxq_pkg::ST_SWITCHED_ON: begin
            if (cw == dcaxq_pkg::CW_ENABLE_OP) begin
              nxt_state = dcaxq_pkg::ST_OP_EN;
            end else if ((cw & dcaxq_pkg::CW_SHUTDOWN_MASK) == dcaxq_pkg::CW_SHUTDOWN) begin
              nxt_state = dcaxq_pkg::ST_READY;
            end
          end
          dcaxq_pkg::ST_OP_EN: begin
            if (cw == dcaxq_pkg::CW_SWITCH_ON) begin
              nxt_state = dcaxq_pkg::ST_SWITCHED_ON;
            end else if ((cw & dcaxq_pkg::CW_SHUTDOWN_MASK) == dcaxq_pkg::CW_SHUTDOWN) begin
              nxt_state = dcaxq_pkg::ST_READY;
            end
          end
          default: begin
            nxt_state = dcaxq_pkg::ST_SW_ON_DIS;
          end
        endcase
      end
    end
  end

  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      state_ff <= dcaxq_pkg::ST_SW_ON_DIS;
      ctrl_ff  <= dcaxq_pkg::RST_CTRL;
    end else begin
      state_ff <= nxt_state;
      ctrl_ff  <= nxt_ctrl;
    end
  end

  // Configuration and current registers
  always_comb begin
    nxt_four_edge = four_edge_ff;
    nxt_cur_set   = cur_set_ff;
    nxt_lim       = lim_ff;
    if (WR) begin
      case (ADDR)
        dcaxq_pkg::OFS_CFG:     nxt_four_edge = WDATA[dcaxq_pkg::CFG_FOUR_EDGE_BIT];
        dcaxq_pkg::OFS_CUR_SET: nxt_cur_set   = WDATA[dcaxq_pkg::CUR_W-1:0];
        dcaxq_pkg::OFS_LIM_POS: nxt_lim.pos   = WDATA[dcaxq_pkg::CUR_W-1:0];
        dcaxq_pkg::OFS_LIM_NEG: nxt_lim.neg   = WDATA[dcaxq_pkg::CUR_W-1:0];
        dcaxq_pkg::OFS_MAX_CUR: nxt_lim.max   = WDATA[dcaxq_pkg::CUR_W-1:0];
        default:                nxt_four_edge = four_edge_ff;
      endcase
    end
  end

  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      four_edge_ff <= dcaxq_pkg::RST_FOUR_EDGE;
      cur_set_ff   <= dcaxq_pkg::RST_CUR_SET;
      lim_ff.pos   <= dcaxq_pkg::RST_CUR_LIMIT;
      lim_ff.neg   <= dcaxq_pkg::RST_CUR_LIMIT;
      lim_ff.max   <= dcaxq_pkg::RST_CUR_LIMIT;
    end else begin
      four_edge_ff <= nxt_four_edge;
      cur_set_ff   <= nxt_cur_set;
      lim_ff       <= nxt_lim;
    end
  end

  // Position, direction and velocity window
  always_comb begin
    nxt_pos      = pos_ff;
    nxt_dir      = dir_ff;
    nxt_pos_prev = pos_prev_ff;
    nxt_vel      = vel_ff;
    nxt_win      = win_ff + 1'b1;
    if (step.step) begin
      nxt_dir = step.up;
      if (step.up) begin
        nxt_pos = pos_ff + 1'b1;
      end else begin
        nxt_pos = pos_ff - 1'b1;
      end
    end
    // Sign of the difference gives direction of travel over the window
    if (win_ff == WIN_LAST) begin
      nxt_win      = '0;
      nxt_vel      = pos_ff - pos_prev_ff;
      nxt_pos_prev = pos_ff;
    end
  end

  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      pos_ff      <= '0;
      dir_ff      <= 1'b0;
      pos_prev_ff <= '0;
      vel_ff      <= '0;
      win_ff      <= '0;
    end else begin
      pos_ff      <= nxt_pos;
      dir_ff      <= nxt_dir;
      pos_prev_ff <= nxt_pos_prev;
      vel_ff      <= nxt_vel;
      win_ff      <= nxt_win;
    end
  end

  // Current clamp and power stage steering
  always_comb begin
    cur_neg = cur_set_ff[dcaxq_pkg::CUR_W-1];
    cur_mag = cur_neg ? (~cur_set_ff + 1'b1) : cur_set_ff;
    cur_lim = cur_neg ? lim_ff.neg : lim_ff.pos;
    if (lim_ff.max < cur_lim) begin
      cur_lim = lim_ff.max;
    end
    cur_eff = (cur_mag < cur_lim) ? cur_mag : cur_lim;
    // Setpoint units are PWM clock cycles, so full scale is one period
    if (cur_eff > PERIOD_CUR) begin
      cur_eff = PERIOD_CUR;
    end
    if (state_ff == dcaxq_pkg::ST_OP_EN) begin
      duty = cur_eff[dcaxq_pkg::DUTY_W-1:0];
    end else begin
      duty = '0;
    end
    nxt_drive_en = (state_ff == dcaxq_pkg::ST_OP_EN);
    // Only one bridge side switches, so the motor leads are never both high
    nxt_motor_p  = nxt_drive_en && !cur_neg && pwm_on;
    nxt_motor_n  = nxt_drive_en && cur_neg && pwm_on;
  end

  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      motor_p_ff  <= 1'b0;
      motor_n_ff  <= 1'b0;
      drive_en_ff <= 1'b0;
    end else begin
      motor_p_ff  <= nxt_motor_p;
      motor_n_ff  <= nxt_motor_n;
      drive_en_ff <= nxt_drive_en;
    end
  end

  // Read port: data stands for the one cycle after the strobe, zero otherwise
  always_comb begin
    nxt_rdata = '0;
    if (RD) begin
      case (ADDR)
        dcaxq_pkg::OFS_CTRL: nxt_rdata[3:0] = ctrl_ff;
        dcaxq_pkg::OFS_STATUS: begin
          nxt_rdata[1:0]                     = state_ff;
          nxt_rdata[dcaxq_pkg::ST_DIR_BIT]   = dir_ff;
          nxt_rdata[dcaxq_pkg::ST_RDY_BIT]   = (state_ff != dcaxq_pkg::ST_SW_ON_DIS);
          nxt_rdata[dcaxq_pkg::ST_SWON_BIT]  = state_ff[1];
          nxt_rdata[dcaxq_pkg::ST_OPEN_BIT]  = (state_ff == dcaxq_pkg::ST_OP_EN);
        end
        dcaxq_pkg::OFS_POSITION: nxt_rdata = pos_ff;
        dcaxq_pkg::OFS_VELOCITY: nxt_rdata = vel_ff;
        dcaxq_pkg::OFS_CUR_SET:  nxt_rdata[dcaxq_pkg::CUR_W-1:0] = cur_set_ff;
        dcaxq_pkg::OFS_LIM_POS:  nxt_rdata[dcaxq_pkg::CUR_W-1:0] = lim_ff.pos;
        dcaxq_pkg::OFS_LIM_NEG:  nxt_rdata[dcaxq_pkg::CUR_W-1:0] = lim_ff.neg;
        dcaxq_pkg::OFS_MAX_CUR:  nxt_rdata[dcaxq_pkg::CUR_W-1:0] = lim_ff.max;
        dcaxq_pkg::OFS_CFG:      nxt_rdata[dcaxq_pkg::CFG_FOUR_EDGE_BIT] = four_edge_ff;
        default:                 nxt_rdata = '0;
      endcase
    end
  end

  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      rdata_ff <= '0;
    end else begin
      rdata_ff <= nxt_rdata;
    end
  end

  assign RDATA    = rdata_ff;
  assign MOTOR_P  = motor_p_ff;
  assign MOTOR_N  = motor_n_ff;
  assign DRIVE_EN = drive_en_ff;

endmodule

/* bench/dcaxq_checker.sv */
// Port-level assertion checker for the DC axis block
`timescale 1ns/1ns
module dcaxq_checker #(
  parameter int VEL_WIN_CYC = dcaxq_pkg::VEL_WIN_CYC
) (
  // Clock and reset
  input wire logic        CLK,
  input wire logic        RESET,
  // Register port
  input wire logic [7:0]  ADDR,
  input wire logic [31:0] WDATA,
  input wire logic        WR,
  input wire logic        RD,
  input wire logic [31:0] RDATA,
  // Encoder and drive
  input wire logic        TRACK_A,
  input wire logic        TRACK_B,
  input wire logic        MOTOR_P,
  input wire logic        MOTOR_N,
  input wire logic        DRIVE_EN
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RESET);
  int unsigned gap_ff;
  int unsigned nxt_gap;
  logic        seen_ff;
  logic        nxt_seen;
  logic        p_ff;
  // Rises of the positive drive must sit on whole base periods, whatever the duty
  always_comb begin
    nxt_seen = seen_ff | (MOTOR_P & ~p_ff);
    nxt_gap  = (MOTOR_P & ~p_ff) ? 1 : gap_ff + 1;
  end
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      gap_ff  <= 0;
      seen_ff <= 1'b0;
      p_ff    <= 1'b0;
    end else begin
      gap_ff  <= nxt_gap;
      seen_ff <= nxt_seen;
      p_ff    <= MOTOR_P;
    end
  end
  sequence ctrl_wr;
    WR && ADDR == dcaxq_pkg::OFS_CTRL;
  endsequence
  sequence status_rd;
    RD && ADDR == dcaxq_pkg::OFS_STATUS;
  endsequence
  rdata_idle_a: assert property (!$past(RD) |-> RDATA == 32'h0)
    else $error("read data seen outside its slot");
  drive_excl_a: assert property (!(MOTOR_P && MOTOR_N))
    else $error("both bridge sides driven");
  motor_gate_a: assert property (!DRIVE_EN [*4] |-> !MOTOR_P && !MOTOR_N)
    else $error("motor driven while not enabled");
  drive_cause_a: assert property ($changed(DRIVE_EN) |->
    $past(WR, 2) && $past(ADDR, 2) == dcaxq_pkg::OFS_CTRL)
    else $error("drive enable moved without a command");
  enable_code_a: assert property ($rose(DRIVE_EN) |->
    $past(WDATA[3:0], 2) == dcaxq_pkg::CW_ENABLE_OP)
    else $error("drive enabled by wrong code");
  volt_off_a: assert property (ctrl_wr ##0 !WDATA[1] |-> ##2 !DRIVE_EN)
    else $error("drive stayed on after voltage off");
  status_view_a: assert property (status_rd |=> RDATA[10] == DRIVE_EN &&
    RDATA[8] == (RDATA[1:0] != 2'h0))
    else $error("status word disagrees with drive");
  pwm_period_a: assert property (MOTOR_P && !p_ff && seen_ff |->
    gap_ff % dcaxq_pkg::PWM_PERIOD_CYC == 0)
    else $error("drive period off its base");
endmodule

bind dcaxq_top dcaxq_checker #(.VEL_WIN_CYC(VEL_WIN_CYC)) u_chk (
  .CLK(CLK), .RESET(RESET), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
  .RDATA(RDATA), .TRACK_A(TRACK_A), .TRACK_B(TRACK_B), .MOTOR_P(MOTOR_P),
  .MOTOR_N(MOTOR_N), .DRIVE_EN(DRIVE_EN)
);

/* bench/dcaxq_enc.sv */
// Behavioural incremental encoder with two tracks
`timescale 1ns/1ns
module dcaxq_enc (
  // Launch clock
  input  wire logic clk,
  // Tracks
  output logic      trk_a,
  output logic      trk_b
);
  logic [1:0] ph;
  initial begin
    ph    = 2'h0;
    trk_a = 1'b0;
    trk_b = 1'b0;
  end
  // Phase order 00,10,11,01 keeps A a quarter period ahead of B going up
  task automatic move(input bit up, input int n, input int gap);
    for (int i = 0; i < n; i++) begin
      @(posedge clk);
      ph = up ? ph + 2'h1 : ph - 2'h1;
      trk_a <= ph[1] ^ ph[0];
      trk_b <= ph[1];
      repeat (gap) @(posedge clk);
    end
  endtask
  // Both tracks flip at once; a sound encoder never does this
  task automatic jolt();
    @(posedge clk);
    ph = ph + 2'h2;
    trk_a <= ph[1] ^ ph[0];
    trk_b <= ph[1];
    repeat (8) @(posedge clk);
  endtask
endmodule

/* bench/tb_top.sv */
// Self-checking bench for the DC axis block
`timescale 1ns/1ns
module tb_top;
  localparam logic [7:0]  A_CT = dcaxq_pkg::OFS_CTRL;
  localparam logic [7:0]  A_ST = dcaxq_pkg::OFS_STATUS;
  localparam logic [7:0]  A_PS = dcaxq_pkg::OFS_POSITION;
  localparam logic [31:0] ALL  = 32'hffffffff;
  logic        clk;
  logic        reset;
  logic        wr_s;
  logic        rd_s;
  logic [7:0]  addr;
  logic [31:0] wdata;
  logic [31:0] rdata;
  logic        trk_a;
  logic        trk_b;
  logic        motor_p;
  logic        motor_n;
  logic        drive_en;
  int          failures;
  int          n_checks;
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  dcaxq_top #(.VEL_WIN_CYC(50)) dut (
    .CLK(clk), .RESET(reset), .ADDR(addr), .WDATA(wdata), .WR(wr_s), .RD(rd_s),
    .RDATA(rdata), .TRACK_A(trk_a), .TRACK_B(trk_b), .MOTOR_P(motor_p),
    .MOTOR_N(motor_n), .DRIVE_EN(drive_en)
  );
  dcaxq_enc enc (.clk(clk), .trk_a(trk_a), .trk_b(trk_b));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    wr_s  <= 1'b1;
    addr  <= a;
    wdata <= d;
    @(posedge clk);
    wr_s  <= 1'b0;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    @(posedge clk);
    rd_s <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd_s <= 1'b0;
    #1;
    check(rdata & m, e);
  endtask
  function automatic logic [31:0] stw(input int s);
    stw = {21'h0, s == 3, s >= 2, s != 0, 6'h0, 2'(s)};
  endfunction
  // Counts high cycles over one whole base period after a settling period
  task automatic meas(input int ep, input int en);
    int hp;
    int hn;
    hp = 0;
    hn = 0;
    repeat (3130) @(posedge clk);
    for (int i = 0; i < 3125; i++) begin
      @(posedge clk);
      #1;
      hp += int'(motor_p === 1'b1);
      hn += int'(motor_n === 1'b1);
    end
    check(32'(hp), 32'(ep));
    check(32'(hn), 32'(en));
  endtask
  task automatic t_reset();
    logic [31:0] e [10] = '{0, 0, 0, 0, 0, 32'hc35, 32'hc35, 32'hc35, 1, 0};
    for (int i = 0; i < 10; i++) rchk(8'(i * 4), ALL, e[i]);
    check({29'h0, drive_en, motor_p, motor_n}, 32'h0);
    $display("reset values done");
  endtask
  task automatic t_states();
    wr(A_CT, 32'h7);
    rchk(A_ST, 32'h703, stw(0));
    wr(A_CT, 32'he);
    rchk(A_ST, 32'h703, stw(1));
    wr(A_CT, 32'h0);
    rchk(A_ST, 32'h703, stw(0));
    wr(A_CT, 32'h6);
    wr(A_CT, 32'hf);
    rchk(A_ST, 32'h703, stw(1));
    wr(A_CT, 32'h7);
    rchk(A_ST, 32'h703, stw(2));
    wr(A_CT, 32'hf);
    wr(A_ST, 32'h0);
    rchk(A_ST, 32'h703, stw(3));
    check({31'h0, drive_en}, 32'h1);
    $display("state sequence done");
  endtask
  task automatic t_quad();
    enc.move(1, 8, 6);
    rchk(A_PS, ALL, 32'h8);
    rchk(A_ST, 32'h10, 32'h10);
    enc.move(0, 3, 6);
    rchk(A_PS, ALL, 32'h5);
    rchk(A_ST, 32'h10, 32'h0);
    enc.jolt();
    rchk(A_PS, ALL, 32'h5);
    $display("four-edge done");
  endtask
  task automatic t_single();
    wr(dcaxq_pkg::OFS_CFG, 32'h0);
    enc.move(1, 8, 6);
    rchk(A_PS, ALL, 32'h7);
    enc.move(0, 8, 6);
    rchk(A_PS, ALL, 32'h5);
    wr(dcaxq_pkg::OFS_CFG, 32'h1);
    $display("single-edge done");
  endtask
  // One step every ten cycles gives exactly five counts per window
  task automatic t_vel();
    enc.move(1, 20, 9);
    rchk(dcaxq_pkg::OFS_VELOCITY, ALL, 32'h5);
    enc.move(0, 20, 9);
    rchk(dcaxq_pkg::OFS_VELOCITY, ALL, 32'hfffffffb);
    rchk(A_PS, ALL, 32'h5);
    $display("velocity done");
  endtask
  task automatic t_drive();
    wr(dcaxq_pkg::OFS_CUR_SET, 32'h64);
    meas(100, 0);
    wr(dcaxq_pkg::OFS_LIM_POS, 32'h28);
    meas(40, 0);
    wr(dcaxq_pkg::OFS_MAX_CUR, 32'h3c);
    wr(dcaxq_pkg::OFS_CUR_SET, 32'hff38);
    meas(0, 60);
    wr(dcaxq_pkg::OFS_LIM_NEG, 32'h19);
    meas(0, 25);
    wr(A_CT, 32'h7);
    rchk(A_ST, 32'h703, stw(2));
    repeat (6) @(posedge clk);
    check({30'h0, motor_p, motor_n}, 32'h0);
    wr(A_CT, 32'h6);
    rchk(A_ST, 32'h703, stw(1));
    $display("drive limits done");
  endtask
  // Reset while track B idles high: the refilling synchroniser must not count
  task automatic t_rst2();
    @(posedge clk);
    reset <= 1'b1;
    repeat (3) @(posedge clk);
    reset <= 1'b0;
    repeat (8) @(posedge clk);
    rchk(A_PS, ALL, 32'h0);
    rchk(A_ST, 32'h713, 32'h0);
    $display("mid-run reset done");
  endtask
  initial begin
    reset    = 1'b1;
    wr_s     = 1'b0;
    rd_s     = 1'b0;
    addr     = 8'h0;
    wdata    = 32'h0;
    failures = 0;
    n_checks = 0;
    repeat (12) @(posedge clk);
    reset <= 1'b0;
    t_reset();
    t_states();
    t_quad();
    t_single();
    t_vel();
    t_drive();
    t_rst2();
    tally_and_finish();
  end
  // A hang counts as a mismatch
  initial begin
    repeat (100000) @(posedge clk);
    failures++;
    tally_and_finish();
  end
endmodule
